/* File: core/i2cm_pkg.sv */
package i2cm_pkg;
   // ----------------------------------------
   // sizes and rates
   // ----------------------------------------
   localparam int NUM_BUS = 24;
   localparam int BUS_W = 5;
   localparam int CLK_HZ = 25_000_000;
   localparam int LINK_HZ = 8_000_000;
   localparam int SCL_HZ = 100_000;
   localparam int QTR_CYC = LINK_HZ / (4 * SCL_HZ);
   localparam int WR_HOLD_MS = 5;
   localparam int WR_HOLD_CYC = CLK_HZ / 1000 * WR_HOLD_MS;
   localparam int XFER_LIMIT = (36 * QTR_CYC + 16) * (CLK_HZ / 1_000_000)
                               / (LINK_HZ / 1_000_000) + 16;
   // ----------------------------------------
   // memory slave addressing
   // ----------------------------------------
   localparam logic [3:0] CTRL_PREFIX = 4'ha;
   localparam logic [2:0] WR_DATA_BYTES = 3'h4;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_START = 3'h0,
      OP_STOP = 3'h1,
      OP_WRITE = 3'h2,
      OP_READ = 3'h3,
      OP_CTRL = 3'h4
   } i2cm_op_t;
   typedef enum logic [1:0] {
      LK_START = 2'h0,
      LK_STOP = 2'h1,
      LK_BYTE = 2'h2
   } i2cm_kind_t;
   typedef enum logic [1:0] {
      LS_IDLE = 2'h0,
      LS_RUN = 2'h1,
      LS_DONE = 2'h3
   } i2cm_lst_t;
   typedef enum logic [1:0] {
      FS_IDLE = 2'h0,
      FS_WAIT = 2'h1,
      FS_BUSY = 2'h3
   } i2cm_fst_t;
endpackage

/* File: core/i2cm_link.sv */
`timescale 1ns/1ns
module i2cm_link #(
   parameter int NB = i2cm_pkg::NUM_BUS
) (
   input wire logic link_clk,
   input wire logic rst_raw,
   input wire logic en_raw,
   input wire logic req_t,
   input wire i2cm_pkg::i2cm_kind_t req_kind,
   input wire logic req_rep,
   input wire logic [i2cm_pkg::BUS_W-1:0] req_bus,
   input wire logic [8:0] req_sh,
   output logic done_t,
   output logic [8:0] rsp_sh,
   output logic rsp_err,
   input wire logic [NB-1:0] scl_i,
   input wire logic [NB-1:0] sda_i,
   output logic [NB-1:0] scl_o,
   output logic [NB-1:0] sda_o,
   output logic [NB-1:0] scl_oe_n,
   output logic [NB-1:0] sda_oe_n
);
   import i2cm_pkg::*;

   localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

   typedef struct packed {
      logic [2:0] rs;
      logic [2:0] es;
      logic ef;
      logic [2:0] rq;
      logic rf;
      logic [NB-1:0] c1, c2, c3, cf;
      logic [NB-1:0] a1, a2, a3, af;
      i2cm_lst_t st;
      i2cm_kind_t kind;
      logic [BUS_W-1:0] bus;
      logic [8:0] sh;
      logic [3:0] cnt;
      logic [1:0] ph;
      logic [7:0] qc;
      logic err;
      logic done_t;
      logic [NB-1:0] scl_oe_n, sda_oe_n, scl_o, sda_o;
   } i2cm_lk_t;

   i2cm_lk_t lk_q;
   i2cm_lk_t lk_d;

   // a level counts once the second and third stage agree
   function automatic logic [NB-1:0] agree(input logic [NB-1:0] a, input logic [NB-1:0] b,
                                           input logic [NB-1:0] f);
      return (~(a ^ b) & b) | ((a ^ b) & f);
   endfunction

   always_comb begin
      lk_d = lk_q;
      if (lk_q.rs[2] && lk_q.rs[1]) begin
         lk_d = '0;
         lk_d.scl_oe_n = '1;
         lk_d.sda_oe_n = '1;
         // filters start at the idle level, so a fresh start right after reset is not refused
         lk_d.c1 = '1;
         lk_d.c2 = '1;
         lk_d.c3 = '1;
         lk_d.cf = '1;
         lk_d.a1 = '1;
         lk_d.a2 = '1;
         lk_d.a3 = '1;
         lk_d.af = '1;
      end else if (lk_q.ef) begin
         lk_d.rq = {lk_q.rq[1:0], req_t};
         lk_d.c1 = scl_i;
         lk_d.c2 = lk_q.c1;
         lk_d.c3 = lk_q.c2;
         lk_d.cf = agree(lk_q.c2, lk_q.c3, lk_q.cf);
         lk_d.a1 = sda_i;
         lk_d.a2 = lk_q.a1;
         lk_d.a3 = lk_q.a2;
         lk_d.af = agree(lk_q.a2, lk_q.a3, lk_q.af);
         case (lk_q.st)
            LS_IDLE: begin
               if (lk_q.rq[2] == lk_q.rq[1] && lk_q.rq[2] != lk_q.rf) begin
                  lk_d.rf = lk_q.rq[2];
                  lk_d.kind = req_kind;
                  lk_d.bus = req_bus;
                  lk_d.sh = req_sh;
                  lk_d.cnt = 4'h0;
                  lk_d.ph = 2'h0;
                  lk_d.qc = 8'h00;
                  lk_d.err = 1'b0;
                  lk_d.st = LS_RUN;
                  // fresh start only on an idle pair: both lines high, see RULE1
                  if (req_kind == LK_START && !req_rep
                      && !(lk_q.cf[req_bus] && lk_q.af[req_bus])) begin
                     lk_d.err = 1'b1;
                     lk_d.st = LS_DONE;
                  end
               end
            end
            LS_RUN: begin
               // every edge of the clock line is ours; nothing waits on a slave, see RULE14
               lk_d.qc = lk_q.qc + 8'h01;
               if (lk_q.qc == QTR_LAST) begin
                  lk_d.qc = 8'h00;
                  lk_d.ph = lk_q.ph + 2'h1;
                  case (lk_q.ph)
                     2'h0: lk_d.sda_oe_n[lk_q.bus] = (lk_q.kind != LK_STOP)
                                                     && ((lk_q.kind == LK_START) || lk_q.sh[8]);
                     2'h1: lk_d.scl_oe_n[lk_q.bus] = 1'b1;
                     2'h2: begin
                        if (lk_q.kind == LK_BYTE) begin
                           lk_d.sh = {lk_q.sh[7:0], lk_q.af[lk_q.bus]};
                        end else begin
                           lk_d.sda_oe_n[lk_q.bus] = (lk_q.kind == LK_STOP);
                        end
                     end
                     default: begin
                        lk_d.cnt = lk_q.cnt + 4'h1;
                        if (lk_q.kind != LK_STOP) begin
                           lk_d.scl_oe_n[lk_q.bus] = 1'b0;
                        end
                        // eight data bits plus the acknowledge slot, see RULE9
                        if (lk_q.kind != LK_BYTE || lk_q.cnt == 4'h8) begin
                           lk_d.st = LS_DONE;
                        end
                     end
                  endcase
               end
            end
            LS_DONE: begin
               lk_d.done_t = ~lk_q.done_t;
               lk_d.st = LS_IDLE;
            end
            default: lk_d.st = LS_IDLE;
         endcase
      end
      lk_d.rs = {lk_q.rs[1:0], rst_raw};
      lk_d.es = {lk_q.es[1:0], en_raw};
      if (lk_q.es[2] == lk_q.es[1]) begin
         lk_d.ef = lk_q.es[2];
      end
   end

   always_ff @(posedge link_clk) begin
      lk_q <= lk_d;
   end

   assign done_t = lk_q.done_t;
   assign rsp_sh = lk_q.sh;
   assign rsp_err = lk_q.err;
   assign scl_o = lk_q.scl_o;
   assign sda_o = lk_q.sda_o;
   assign scl_oe_n = lk_q.scl_oe_n;
   assign sda_oe_n = lk_q.sda_oe_n;
endmodule // i2cm_link

/* File: core/i2cm_byte_engine.sv */
// Overview of operation
// RULE1: a pair is idle only while both its clock and data lines read high.
// RULE2: a start request on an idle pair makes a start condition and opens a transaction.
// RULE3: a stop request inside a transaction makes a stop condition and leaves the pair idle.
// RULE4: a start request inside a transaction makes a repeated start with no stop before it.
// RULE5: this block is only ever a master; every other party on the pair is a slave.
// RULE6: no transfer runs on a pair until its pin assignment has been configured.
// RULE7: the memory control byte carries 1010 on top and the chip select in the next three bits.
// RULE8: the control byte's lowest bit is 1 for a read and 0 for a write.
// RULE9: every byte is followed by one acknowledge clock driven by the receiver.
// RULE10: a byte write goes control, high address, low address, data, then stop.
// RULE11: after a memory write about 5 ms pass before the next access to that pair; the code times only the pair written last.
// RULE12: a random read writes control and address, restarts, sends read control, reads, stops.
// RULE13: a slave read on without stop returns consecutive bytes by advancing its address.
// RULE14: the master makes every clock edge and never waits without bound on a slave.
// RULE15: up to 24 independent pairs, each with several slaves, are served.
// RULE16: a byte write reports the sampled acknowledge, 1 meaning no acknowledge.
// RULE17: a byte read shifts in eight bits msb first, then drives the caller's acknowledge.
`timescale 1ns/1ns
module i2cm_byte_engine #(
   parameter int NB = i2cm_pkg::NUM_BUS,
   parameter int WR_HOLD = i2cm_pkg::WR_HOLD_CYC
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic LINK_CLK,
   input wire logic CFG_VALID,
   input wire logic [i2cm_pkg::BUS_W-1:0] CFG_BUS,
   input wire logic CMD_VALID,
   input wire i2cm_pkg::i2cm_op_t CMD_OP,
   input wire logic [i2cm_pkg::BUS_W-1:0] CMD_BUS,
   input wire logic [7:0] CMD_DATA,
   input wire logic CMD_ACK,
   output logic CMD_READY,
   output logic RSP_VALID,
   output logic [7:0] RSP_DATA,
   output logic RSP_NACK,
   output logic RSP_ERR,
   output logic [NB-1:0] BUS_CFG,
   output logic [NB-1:0] BUS_OPEN,
   input wire logic [NB-1:0] SCL_I,
   input wire logic [NB-1:0] SDA_I,
   output logic [NB-1:0] SCL_O,
   output logic [NB-1:0] SDA_O,
   output logic [NB-1:0] SCL_OE_N,
   output logic [NB-1:0] SDA_OE_N
);
   import i2cm_pkg::*;

   localparam int HW = $clog2(WR_HOLD + 1);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      i2cm_fst_t st;
      logic [NB-1:0] cfg;
      logic [NB-1:0] txn;
      logic [2:0] wcnt;
      logic [HW-1:0] hold;
      logic [BUS_W-1:0] hold_bus;
      logic req_t;
      i2cm_op_t op;
      i2cm_kind_t kind;
      logic rep;
      logic [BUS_W-1:0] bus;
      logic [8:0] sh;
      logic [2:0] dn;
      logic df;
      logic ready;
      logic rsp_v;
      logic [7:0] rsp_data;
      logic rsp_nack;
      logic rsp_err;
   } i2cm_fe_t;

   i2cm_fe_t fe_q;
   i2cm_fe_t fe_d;

   logic lk_done_t;
   logic [8:0] lk_sh;
   logic lk_err;
   logic dn_evt;
   logic cmd_ok;
   logic in_txn;
   logic bad;

   function automatic logic bus_ok(input logic [BUS_W-1:0] b);
      return b < BUS_W'(NB);
   endfunction

   // toggle from the link side, filtered like any foreign level
   assign dn_evt = (fe_q.dn[2] == fe_q.dn[1]) && (fe_q.dn[2] != fe_q.df);
   assign cmd_ok = bus_ok(CMD_BUS) && fe_q.cfg[CMD_BUS];
   assign in_txn = cmd_ok && fe_q.txn[CMD_BUS];
   assign bad = !cmd_ok || (CMD_OP > OP_CTRL) || (CMD_OP != OP_START && !in_txn);

   // ----------------------------------------
   // command front end
   // ----------------------------------------
   always_comb begin
      fe_d = fe_q;
      fe_d.rsp_v = 1'b0;
      fe_d.dn = {fe_q.dn[1:0], lk_done_t};
      if (fe_q.dn[2] == fe_q.dn[1]) begin
         fe_d.df = fe_q.dn[2];
      end
      if (fe_q.hold != '0) begin
         fe_d.hold = fe_q.hold - HW'(1);
      end
      // pin assignment per pair; out-of-range pairs are ignored, see RULE15
      if (CFG_VALID && bus_ok(CFG_BUS)) begin
         fe_d.cfg[CFG_BUS] = 1'b1;
      end
      case (fe_q.st)
         FS_IDLE: begin
            if (CMD_VALID && fe_q.ready) begin
               fe_d.op = CMD_OP;
               fe_d.bus = CMD_BUS;
               fe_d.rep = in_txn;
               fe_d.kind = LK_BYTE;
               fe_d.sh = {CMD_DATA, 1'b1};
               if (bad) begin
                  // unconfigured pair, unknown op or no open transaction, see RULE6
                  fe_d.rsp_v = 1'b1;
                  fe_d.rsp_err = 1'b1;
                  fe_d.rsp_nack = 1'b0;
                  fe_d.rsp_data = 8'h00;
               end else begin
                  case (CMD_OP)
                     OP_START: fe_d.kind = LK_START; // see RULE2 RULE4 RULE12
                     OP_STOP: fe_d.kind = LK_STOP; // see RULE3
                     OP_READ: fe_d.sh = {8'hff, CMD_ACK}; // see RULE17
                     OP_CTRL: fe_d.sh = {CTRL_PREFIX, CMD_DATA[2:0], CMD_DATA[3], 1'b1}; // see RULE7 RULE8
                     default: fe_d.sh = {CMD_DATA, 1'b1}; // see RULE9
                  endcase
                  // write recovery only delays the pair that was written, see RULE11
                  if (CMD_OP == OP_START && fe_q.hold != '0 && fe_q.hold_bus == CMD_BUS) begin
                     fe_d.st = FS_WAIT;
                  end else begin
                     fe_d.req_t = ~fe_q.req_t;
                     fe_d.st = FS_BUSY;
                  end
               end
            end
         end
         FS_WAIT: begin
            if (fe_q.hold == '0) begin
               fe_d.req_t = ~fe_q.req_t;
               fe_d.st = FS_BUSY;
            end
         end
         FS_BUSY: begin
            if (dn_evt) begin
               fe_d.st = FS_IDLE;
               fe_d.rsp_v = 1'b1;
               fe_d.rsp_err = lk_err;
               fe_d.rsp_data = lk_sh[8:1];
               fe_d.rsp_nack = lk_sh[0]; // see RULE16
               case (fe_q.kind)
                  LK_START: begin
                     if (!lk_err) begin
                        fe_d.txn[fe_q.bus] = 1'b1;
                        fe_d.wcnt = 3'h0;
                     end
                  end
                  LK_STOP: begin
                     fe_d.txn[fe_q.bus] = 1'b0;
                     // control, two address bytes and data seen: a real write, see RULE10 RULE11
                     if (fe_q.wcnt == WR_DATA_BYTES) begin
                        fe_d.hold = HW'(WR_HOLD);
                        fe_d.hold_bus = fe_q.bus;
                     end
                  end
                  default: begin
                     if (fe_q.op != OP_READ && fe_q.wcnt != WR_DATA_BYTES) begin
                        fe_d.wcnt = fe_q.wcnt + 3'h1;
                     end
                  end
               endcase
            end
         end
         default: fe_d.st = FS_IDLE;
      endcase
      fe_d.ready = (fe_d.st == FS_IDLE);
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         fe_q <= '0;
      end else if (CLK_EN) begin
         fe_q <= fe_d;
      end
   end

   // ----------------------------------------
   // link side
   // ----------------------------------------
   // the pairs are only ever driven low and clocked by us, see RULE5
   i2cm_link #(
      .NB(NB)
   ) u_link (
      .link_clk(LINK_CLK),
      .rst_raw(SYS_RST),
      .en_raw(CLK_EN),
      .req_t(fe_q.req_t),
      .req_kind(fe_q.kind),
      .req_rep(fe_q.rep),
      .req_bus(fe_q.bus),
      .req_sh(fe_q.sh),
      .done_t(lk_done_t),
      .rsp_sh(lk_sh),
      .rsp_err(lk_err),
      .scl_i(SCL_I),
      .sda_i(SDA_I),
      .scl_o(SCL_O),
      .sda_o(SDA_O),
      .scl_oe_n(SCL_OE_N),
      .sda_oe_n(SDA_OE_N)
   );

   assign CMD_READY = fe_q.ready;
   assign RSP_VALID = fe_q.rsp_v;
   assign RSP_DATA = fe_q.rsp_data;
   assign RSP_NACK = fe_q.rsp_nack;
   assign RSP_ERR = fe_q.rsp_err;
   assign BUS_CFG = fe_q.cfg;
   assign BUS_OPEN = fe_q.txn;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [11:0] bcnt_q;
   logic acc;

   assign acc = CLK_EN && CMD_VALID && fe_q.ready && fe_q.st == FS_IDLE;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST || fe_q.st != FS_BUSY) begin
         bcnt_q <= 12'h000;
      end else if (CLK_EN) begin
         bcnt_q <= bcnt_q + 12'h001;
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SYS_RST);

   cfg_refuse_a: assert property ( // see RULE6
      acc && bus_ok(CMD_BUS) && !fe_q.cfg[CMD_BUS]
      |=> RSP_VALID && RSP_ERR && fe_q.st == FS_IDLE && !$changed(fe_q.req_t)
   ) else $error("command ran on an unconfigured pair");

   ctrl_byte_a: assert property ( // see RULE7
      acc && !bad && CMD_OP == OP_CTRL
      |=> fe_q.sh[8:5] == CTRL_PREFIX && fe_q.sh[4:2] == $past(CMD_DATA[2:0])
   ) else $error("control byte prefix or chip select wrong");

   ctrl_dir_a: assert property ( // see RULE8
      acc && !bad && CMD_OP == OP_CTRL |=> fe_q.sh[1] == $past(CMD_DATA[3])
   ) else $error("control byte direction bit wrong");

   rep_start_a: assert property ( // see RULE4
      acc && !bad && CMD_OP == OP_START && in_txn |=> fe_q.rep && fe_q.kind == LK_START
   ) else $error("start inside a transaction not sent as repeated start");

   fresh_start_a: assert property ( // see RULE2
      acc && !bad && CMD_OP == OP_START && !in_txn |=> !fe_q.rep && fe_q.st != FS_IDLE
   ) else $error("start on a closed pair not launched as fresh start");

   stop_close_a: assert property ( // see RULE3
      CLK_EN && fe_q.st == FS_BUSY && fe_q.kind == LK_STOP && dn_evt
      |=> RSP_VALID && !fe_q.txn[$past(fe_q.bus)] && CMD_READY
   ) else $error("stop did not close the transaction");

   ack_slot_a: assert property ( // see RULE9
      fe_q.st == FS_BUSY && fe_q.kind == LK_BYTE && fe_q.op != OP_READ |-> fe_q.sh[0]
   ) else $error("data line not released for the acknowledge clock");

   nack_out_a: assert property ( // see RULE16
      CLK_EN && fe_q.st == FS_BUSY && fe_q.op == OP_WRITE && dn_evt
      |=> RSP_VALID && RSP_NACK == $past(lk_sh[0]) && RSP_DATA == $past(lk_sh[8:1])
   ) else $error("write status does not match sampled acknowledge");

   read_ack_a: assert property ( // see RULE17
      acc && !bad && CMD_OP == OP_READ
      |=> fe_q.sh[8:1] == 8'hff && fe_q.sh[0] == $past(CMD_ACK)
   ) else $error("read byte not set up with caller acknowledge");

   write_hold_a: assert property ( // see RULE11
      CLK_EN && fe_q.st == FS_BUSY && fe_q.kind == LK_STOP && dn_evt
      && fe_q.wcnt == WR_DATA_BYTES
      |=> fe_q.hold == HW'(WR_HOLD) ##1 fe_q.hold != '0
   ) else $error("write recovery time not started");

   hold_block_a: assert property ( // see RULE11
      $changed(fe_q.req_t) && fe_q.kind == LK_START
      |-> $past(fe_q.hold) == '0 || $past(fe_q.hold_bus) != fe_q.bus
   ) else $error("start launched during write recovery");

   bounded_a: assert property ( // see RULE14
      bcnt_q < 12'(XFER_LIMIT)
   ) else $error("transfer did not finish in bounded time");

   start_open_a: assert property ( // see RULE2
      CLK_EN && fe_q.st == FS_BUSY && fe_q.kind == LK_START && dn_evt && !lk_err
      |=> RSP_VALID && !RSP_ERR && fe_q.txn[$past(fe_q.bus)]
   ) else $error("start did not open the transaction");

   busy_refuse_a: assert property ( // see RULE1
      CLK_EN && fe_q.st == FS_BUSY && fe_q.kind == LK_START && dn_evt && lk_err
      |=> RSP_VALID && RSP_ERR && !fe_q.txn[$past(fe_q.bus)]
   ) else $error("start on a busy pair opened a transaction");

   closed_refuse_a: assert property ( // see RULE3
      acc && cmd_ok && CMD_OP != OP_START && !fe_q.txn[CMD_BUS]
      |=> RSP_VALID && RSP_ERR && !$changed(fe_q.req_t)
   ) else $error("command ran on a pair with no open transaction");

   drive_low_a: assert property ( // see RULE5
      SCL_O == '0 && SDA_O == '0
   ) else $error("a pair line was driven high");

   hold_count_a: assert property ( // see RULE11
      CLK_EN && fe_q.hold != '0 && !dn_evt |=> fe_q.hold == $past(fe_q.hold) - HW'(1)
   ) else $error("write recovery count did not advance");

   write_c: cover property (
      fe_q.st == FS_BUSY && fe_q.op == OP_WRITE && dn_evt && !lk_sh[0]
   );
   read_c: cover property (
      fe_q.st == FS_BUSY && fe_q.op == OP_READ && dn_evt
   );
   restart_c: cover property (
      $changed(fe_q.req_t) && fe_q.kind == LK_START && fe_q.rep
   );
   refuse_c: cover property (
      RSP_VALID && RSP_ERR
   );
   hold_c: cover property (
      fe_q.st == FS_WAIT && fe_q.hold == HW'(1)
   );
endmodule // i2cm_byte_engine

/* File: bench/i2cm_eeprom_model.sv */
`timescale 1ns/1ns
module i2cm_eeprom_model #(
   parameter logic [2:0] CS = 3'h0
) (
   input wire logic scl,
   input wire logic sda,
   output logic pull
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, ctl;
   logic [15:0] addr;
   logic act, sel, rd, rd_pend;
   int bitc, byte_n, n_start, n_stop;
   initial begin
      pull = 0; act = 0; sel = 0; rd = 0; rd_pend = 0; bitc = 0; byte_n = 0;
      n_start = 0; n_stop = 0; ctl = 8'h00; addr = 16'h0000; sh = 8'h00;
   end
   // ----------------------------------------
   // frame edges: data moving while clock high
   // ----------------------------------------
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         act = 1; sel = 1; bitc = 0; byte_n = 0; rd = 0; rd_pend = 0;
         n_start++;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         act = 0; rd = 0; n_stop++;
      end
   end
   // ----------------------------------------
   // bit level
   // ----------------------------------------
   always @(posedge scl) begin
      if (act && bitc < 8) begin
         if (!rd) sh = {sh[6:0], sda};
         bitc++;
      end else if (act) begin
         bitc = 0;
         // master nack ends the read, so the stop is never blocked
         if (rd && sda) begin
            rd = 0; act = 0;
         end
      end
   end
   always @(negedge scl) begin
      if (!act || !sel) pull = 0;
      else if (bitc == 8 && !rd) begin
         if (byte_n == 0) begin
            ctl = sh;
            sel = (sh[7:1] == {4'ha, CS});
            rd_pend = sh[0];
         end else if (byte_n == 1) addr[15:8] = sh;
         else if (byte_n == 2) addr[7:0] = sh;
         else begin
            mem[addr[7:0]] = sh;
            addr++;
         end
         byte_n++;
         pull = sel;
      end else if (bitc == 8) pull = 0;
      else if (bitc == 0 && (rd || rd_pend)) begin
         rd = 1; rd_pend = 0;
         sh = mem[addr[7:0]];
         addr++;
         pull = ~sh[7];
      end else if (rd) pull = ~sh[7 - bitc];
      else pull = 0;
   end
endmodule // i2cm_eeprom_model

/* File: bench/i2cm_tb.sv */
`timescale 1ns/1ns
module testbench;
   import i2cm_pkg::*;
   localparam int HOLD = 200;
   localparam int LIM = XFER_LIMIT + HOLD + 400;
   logic CLOCK = 0, SYS_RST = 1, LINK_CLK = 0, CFG_VALID = 0, CMD_VALID = 0, CMD_ACK = 0;
   logic tb_hold = 0, m_pull;
   logic [4:0] CFG_BUS = 5'h00, CMD_BUS = 5'h00;
   i2cm_op_t CMD_OP = OP_START;
   logic [7:0] CMD_DATA = 8'h00, RSP_DATA;
   logic CMD_READY, RSP_VALID, RSP_NACK, RSP_ERR;
   logic [NUM_BUS-1:0] BUS_CFG, BUS_OPEN, SCL_O, SDA_O, SCL_OE_N, SDA_OE_N, scl_w, sda_w, pull_v;
   int errors = 0, checked = 0, n_stop_mark = 0;
   assign pull_v = {21'h000000, tb_hold, 1'b0, m_pull};
   assign scl_w = SCL_OE_N | SCL_O;
   assign sda_w = (SDA_OE_N | SDA_O) & ~pull_v;
   always #20 CLOCK = ~CLOCK;
   always begin
      #62 LINK_CLK = ~LINK_CLK;
      #63 LINK_CLK = ~LINK_CLK;
   end
   i2cm_byte_engine #(.NB(NUM_BUS), .WR_HOLD(HOLD)) i_i2cm_byte_engine (
      .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .LINK_CLK(LINK_CLK),
      .CFG_VALID(CFG_VALID), .CFG_BUS(CFG_BUS), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
      .CMD_BUS(CMD_BUS), .CMD_DATA(CMD_DATA), .CMD_ACK(CMD_ACK), .CMD_READY(CMD_READY),
      .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_NACK(RSP_NACK), .RSP_ERR(RSP_ERR),
      .BUS_CFG(BUS_CFG), .BUS_OPEN(BUS_OPEN), .SCL_I(scl_w), .SDA_I(sda_w), .SCL_O(SCL_O),
      .SDA_O(SDA_O), .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N));
   i2cm_eeprom_model #(.CS(3'h0)) i_i2cm_eeprom_model (
      .scl(scl_w[0]), .sda(sda_w[0]), .pull(m_pull));
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic cmd(input i2cm_op_t op, input logic [4:0] bus, input logic [7:0] d,
                      input logic ack);
      int n;
      n = 0;
      @(negedge CLOCK);
      CMD_OP = op; CMD_BUS = bus; CMD_DATA = d; CMD_ACK = ack; CMD_VALID = 1;
      while (CMD_READY !== 1'b1 && n < LIM) begin
         @(negedge CLOCK);
         n++;
      end
      @(negedge CLOCK);
      CMD_VALID = 0;
      chk(CMD_READY === 1'b0 || RSP_VALID === 1'b1, "ready stays up while busy");
      while (RSP_VALID !== 1'b1 && n < LIM) begin
         @(negedge CLOCK);
         n++;
      end
      chk(n < LIM, "no response in bounded time");
   endtask
   task automatic cfg(input logic [4:0] bus);
      @(negedge CLOCK);
      CFG_BUS = bus; CFG_VALID = 1;
      @(negedge CLOCK);
      CFG_VALID = 0;
   endtask
   task automatic set_addr(input logic [7:0] lo, input logic rd_too);
      cmd(OP_START, 5'd0, 8'h00, 0);
      chk(RSP_ERR === 1'b0 && BUS_OPEN[0] === 1'b1, "start on idle pair");
      cmd(OP_CTRL, 5'd0, 8'h00, 0);
      chk(i_i2cm_eeprom_model.ctl === 8'ha0 && RSP_NACK === 1'b0, "write control");
      cmd(OP_WRITE, 5'd0, 8'h00, 0);
      cmd(OP_WRITE, 5'd0, lo, 0);
      chk(RSP_NACK === 1'b0, "address acknowledged");
      if (rd_too) begin
         n_stop_mark = i_i2cm_eeprom_model.n_stop;
         cmd(OP_START, 5'd0, 8'h00, 0);
         chk(i_i2cm_eeprom_model.n_stop == n_stop_mark && BUS_OPEN[0] === 1'b1,
             "restart without stop");
         cmd(OP_CTRL, 5'd0, 8'h08, 0);
         chk(i_i2cm_eeprom_model.ctl === 8'ha1, "read control");
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_refuse;
      cmd(OP_WRITE, 5'd1, 8'h55, 0);
      chk(RSP_ERR === 1'b1 && SDA_OE_N[1] === 1'b1, "unconfigured pair used");
      cmd(i2cm_op_t'(3'h5), 5'd0, 8'h00, 0);
      chk(RSP_ERR === 1'b1, "bad op taken");
      cmd(OP_STOP, 5'd0, 8'h00, 0);
      chk(RSP_ERR === 1'b1 && SDA_OE_N[0] === 1'b1, "stop with no transaction");
      tb_hold = 1;
      // the held line must pass the pin filter before the start is looked at
      repeat (8) @(negedge CLOCK);
      cmd(OP_START, 5'd2, 8'h00, 0);
      chk(RSP_ERR === 1'b1 && BUS_OPEN[2] === 1'b0, "start on busy pair");
      tb_hold = 0;
   endtask
   task automatic t_write;
      set_addr(8'h13, 0);
      cmd(OP_WRITE, 5'd0, 8'ha1, 0);
      chk(RSP_NACK === 1'b0 && RSP_ERR === 1'b0, "data acknowledged");
      n_stop_mark = i_i2cm_eeprom_model.n_stop;
      cmd(OP_STOP, 5'd0, 8'h00, 0);
      chk(BUS_OPEN[0] === 1'b0 && i_i2cm_eeprom_model.n_stop == n_stop_mark + 1,
          "stop closes");
      chk(i_i2cm_eeprom_model.mem[8'h13] === 8'ha1, "byte stored");
   endtask
   task automatic t_rread;
      set_addr(8'h13, 1);
      cmd(OP_READ, 5'd0, 8'h00, 1);
      chk(RSP_DATA === 8'ha1 && RSP_NACK === 1'b1, "random read data");
      cmd(OP_STOP, 5'd0, 8'h00, 0);
   endtask
   task automatic t_seq;
      i_i2cm_eeprom_model.mem[8'h40] = 8'h3c;
      i_i2cm_eeprom_model.mem[8'h41] = 8'hc5;
      set_addr(8'h40, 1);
      cmd(OP_READ, 5'd0, 8'h00, 0);
      chk(RSP_DATA === 8'h3c && RSP_NACK === 1'b0, "first read byte");
      cmd(OP_READ, 5'd0, 8'h00, 1);
      chk(RSP_DATA === 8'hc5, "next byte follows");
      cmd(OP_STOP, 5'd0, 8'h00, 0);
   endtask
   task automatic t_nack;
      cmd(OP_START, 5'd0, 8'h00, 0);
      cmd(OP_CTRL, 5'd0, 8'h05, 0);
      chk(RSP_NACK === 1'b1 && RSP_DATA === 8'haa, "absent chip nack");
      cmd(OP_STOP, 5'd0, 8'h00, 0);
      chk(BUS_OPEN === 24'h000000 && scl_w[0] === 1'b1 && sda_w[0] === 1'b1, "idle");
   endtask
   task automatic results;
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (16) @(negedge CLOCK);
      SYS_RST = 0;
      repeat (8) @(negedge CLOCK);
      chk(BUS_CFG === 24'h000000 && CMD_READY === 1'b1, "reset state");
      cfg(5'd0);
      cfg(5'd2);
      cfg(5'd30);
      @(negedge CLOCK);
      chk(BUS_CFG === 24'h000005, "configured pairs");
      t_refuse;
      t_write;
      t_rread;
      t_seq;
      t_nack;
      results;
   end
   initial begin
      #2_500_000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      results;
   end
endmodule // testbench
